// ---- verilog/pdh_consts.svh ----
`ifndef PDH_CONSTS_SVH
`define PDH_CONSTS_SVH

// register map
`define PDH_SEL_OFFSET 12'h000
`define PDH_SEL_RESET 16'h0000
`define PDH_SEL_WIDTH 16

// field layout: two bits per pin, pin 16 at bits 1:0
`define PDH_FIELD_WIDTH 2
`define PDH_PIN_COUNT 8
`define PDH_FIRST_PIN 16

// field codes
`define PDH_CODE_PORT 2'b00
`define PDH_CODE_DATA 2'b01
`define PDH_CODE_ALT_A 2'b10
`define PDH_CODE_ALT_B 2'b11

// bus responses
`define PDH_RESP_OKAY 2'b00
`define PDH_RESP_SLVERR 2'b10

`endif

// ---- verilog/pdh_pkg.sv ----
package pdh_pkg;

   // who owns a pin
   typedef enum logic [2:0]
   {
      pdh_own_gpio,
      pdh_own_data,
      pdh_own_alt_a,
      pdh_own_alt_b,
      pdh_own_none
   } pdh_owner_t;

   // operating mode straps
   typedef struct packed
   {
      logic rom_disabled;
      logic chip_select_zero_32bit;
      logic single_chip;
   } pdh_mode_t;

   // drive toward one pad
   typedef struct packed
   {
      logic out;
      logic oe_n;
   } pdh_pad_t;

endpackage

// ---- verilog/pdh_pin_function_sel.sv ----
`timescale 1ns/1ps
`include "pdh_consts.svh"

// Operation
// - sixteen-bit register, two bits per pin 23..16
// - register resets to zero, all pins general I/O except data bus in 32-bit ROMless
// - code 00 gives data bus in 32-bit ROMless
// - code 01 data bus, general I/O single-chip
// - pin 23: PWM cycle/clear, serial 1 clock
// - pin 22: PWM W phase, serial 0 clock
// - pin 21: PWM V phase, interrupt 7
// - pin 20: PWM U phase, interrupt 6
// - pin 19: output enable 3, interrupt 5
// - pin 18: output enable 2, interrupt 4
// - pin 17: output enable 1, A/D trigger
// - pin 16: output enable 0, code 11 reserved
module pdh_pin_function_sel
   import pdh_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // axi4-lite write address
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // operating mode
   input wire pdh_mode_t mode_in,
   // pads, index 0 is pin 16
   input wire logic [7:0] pin_in,
   output pdh_pad_t [7:0] pad_drive,
   // general-purpose port
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe,
   output logic [7:0] gpio_in,
   // external data bus bits 23..16
   input wire logic [7:0] dbus_out,
   input wire logic [7:0] dbus_oe,
   output logic [7:0] dbus_in,
   // motor timer outputs toward pads
   input wire logic pwm_cycle_out,
   input wire logic pwm_w_phase_out,
   input wire logic pwm_v_phase_out,
   input wire logic pwm_u_phase_out,
   // motor timer inputs from pads
   output logic pwm_counter_clear_in,
   output logic output_enable_in_3,
   output logic output_enable_in_2,
   output logic output_enable_in_1,
   output logic output_enable_in_0,
   // serial clocks
   input wire logic serial1_clock_out,
   input wire logic serial1_clock_oe,
   output logic serial1_clock_in,
   input wire logic serial0_clock_out,
   input wire logic serial0_clock_oe,
   output logic serial0_clock_in,
   // interrupt and trigger inputs
   output logic ext_irq_7,
   output logic ext_irq_6,
   output logic ext_irq_5,
   output logic ext_irq_4,
   output logic adc_external_trigger
);

   // maps a field code to the pin owner
   function automatic pdh_owner_t owner_of(input logic [1:0] code, input logic no_alt_b, input pdh_mode_t m);
      pdh_owner_t own;
      own = pdh_own_gpio;
      case (code)
         `PDH_CODE_PORT:
            own = (m.rom_disabled && m.chip_select_zero_32bit) ? pdh_own_data : pdh_own_gpio;
         `PDH_CODE_DATA:
            own = m.single_chip ? pdh_own_gpio : pdh_own_data;
         `PDH_CODE_ALT_A:
            own = pdh_own_alt_a;
         `PDH_CODE_ALT_B:
            own = no_alt_b ? pdh_own_none : pdh_own_alt_b;
         default:
            own = pdh_own_gpio;
      endcase
      return own;
   endfunction

   // address match against the single register
   function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a);
      return a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(`PDH_SEL_OFFSET >> 2);
   endfunction

   logic [15:0] sel_reg;
   logic [15:0] sel_next;
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_WIDTH-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // bus handshake decode
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_hit = addr_hit(awaddr_reg);
   wire rd_hit = addr_hit(s_axi_araddr);
   wire wr_apply = wr_fire && wr_hit;

   // read data and responses
   wire [31:0] rd_word = rd_hit ? {16'h0, sel_reg} : 32'h0;
   wire [1:0] rd_resp = rd_hit ? `PDH_RESP_OKAY : `PDH_RESP_SLVERR;
   wire [1:0] wr_resp = wr_hit ? `PDH_RESP_OKAY : `PDH_RESP_SLVERR;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // byte-lane merge of a write
   always_comb
   begin
      sel_next = sel_reg;
      if (wr_apply)
      begin
         if (wstrb_reg[0])
            sel_next[7:0] = wdata_reg[7:0];
         if (wstrb_reg[1])
            sel_next[15:8] = wdata_reg[15:8];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         sel_reg <= `PDH_SEL_RESET;
      else
         sel_reg <= sel_next;
   end

   // write address and data capture, either order
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_held_reg <= 1'b0;
         if (w_take)
         begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_reg <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `PDH_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_resp;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // read channel, upper bits zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `PDH_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_resp;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // alternate function drive per pin
   wire [7:0] alt_a_out;
   wire [7:0] alt_a_drv;
   wire [7:0] alt_b_out;
   wire [7:0] alt_b_drv;

   // code 10 outputs, pins 19..16 input only
   assign alt_a_out[7] = pwm_cycle_out;
   assign alt_a_out[6] = pwm_w_phase_out;
   assign alt_a_out[5] = pwm_v_phase_out;
   assign alt_a_out[4] = pwm_u_phase_out;
   assign alt_a_out[3:0] = 4'h0;
   assign alt_a_drv[7:4] = 4'hf;
   assign alt_a_drv[3:0] = 4'h0;

   // code 11 outputs, only the serial clocks drive
   assign alt_b_out[7] = serial1_clock_out;
   assign alt_b_out[6] = serial0_clock_out;
   assign alt_b_out[5:0] = 6'h00;
   assign alt_b_drv[7] = serial1_clock_oe;
   assign alt_b_drv[6] = serial0_clock_oe;
   assign alt_b_drv[5:0] = 6'h00;

   pdh_owner_t owner [7:0];
   logic [7:0] is_gpio;
   logic [7:0] is_data;
   logic [7:0] is_alt_a;
   logic [7:0] is_alt_b;

   // named field bits, pin 23 at the top
   wire pin23_sel_hi = sel_reg[`PDH_FIELD_WIDTH*7+1];
   wire pin23_sel_lo = sel_reg[`PDH_FIELD_WIDTH*7];
   wire pin22_sel_hi = sel_reg[`PDH_FIELD_WIDTH*6+1];
   wire pin22_sel_lo = sel_reg[`PDH_FIELD_WIDTH*6];
   wire pin21_sel_hi = sel_reg[`PDH_FIELD_WIDTH*5+1];
   wire pin21_sel_lo = sel_reg[`PDH_FIELD_WIDTH*5];
   wire pin20_sel_hi = sel_reg[`PDH_FIELD_WIDTH*4+1];
   wire pin20_sel_lo = sel_reg[`PDH_FIELD_WIDTH*4];
   wire pin19_sel_hi = sel_reg[`PDH_FIELD_WIDTH*3+1];
   wire pin19_sel_lo = sel_reg[`PDH_FIELD_WIDTH*3];
   wire pin18_sel_hi = sel_reg[`PDH_FIELD_WIDTH*2+1];
   wire pin18_sel_lo = sel_reg[`PDH_FIELD_WIDTH*2];
   wire pin17_sel_hi = sel_reg[`PDH_FIELD_WIDTH*1+1];
   wire pin17_sel_lo = sel_reg[`PDH_FIELD_WIDTH*1];
   wire pin16_sel_hi = sel_reg[`PDH_FIELD_WIDTH*0+1];
   wire pin16_sel_lo = sel_reg[`PDH_FIELD_WIDTH*0];
   wire [15:0] field_bits = {pin23_sel_hi, pin23_sel_lo, pin22_sel_hi, pin22_sel_lo, pin21_sel_hi, pin21_sel_lo,
      pin20_sel_hi, pin20_sel_lo, pin19_sel_hi, pin19_sel_lo, pin18_sel_hi, pin18_sel_lo,
      pin17_sel_hi, pin17_sel_lo, pin16_sel_hi, pin16_sel_lo};

   // only pin 16 lacks a second alternate
   wire [7:0] no_alt_b = 8'h01;

   // pad mux
   for (genvar i = 0; i < `PDH_PIN_COUNT; i++)
   begin : g_pin
      assign owner[i] = owner_of(field_bits[`PDH_FIELD_WIDTH*i +: `PDH_FIELD_WIDTH], no_alt_b[i], mode_in);
      assign is_gpio[i] = owner[i] == pdh_own_gpio;
      assign is_data[i] = owner[i] == pdh_own_data;
      assign is_alt_a[i] = owner[i] == pdh_own_alt_a;
      assign is_alt_b[i] = owner[i] == pdh_own_alt_b;
      always_comb
      begin
         pad_drive[i].out = 1'b0;
         pad_drive[i].oe_n = 1'b1;
         case (owner[i])
            pdh_own_gpio:
            begin
               pad_drive[i].out = gpio_out[i];
               pad_drive[i].oe_n = !gpio_oe[i];
            end
            pdh_own_data:
            begin
               pad_drive[i].out = dbus_out[i];
               pad_drive[i].oe_n = !dbus_oe[i];
            end
            pdh_own_alt_a:
            begin
               pad_drive[i].out = alt_a_out[i];
               pad_drive[i].oe_n = !alt_a_drv[i];
            end
            pdh_own_alt_b:
            begin
               pad_drive[i].out = alt_b_out[i];
               pad_drive[i].oe_n = !alt_b_drv[i];
            end
            default:
            begin
               pad_drive[i].out = 1'b0;
               pad_drive[i].oe_n = 1'b1;
            end
         endcase
      end
   end

   // inputs toward owners, zero when not selected
   assign gpio_in = pin_in & is_gpio;
   assign dbus_in = pin_in & is_data;
   assign pwm_counter_clear_in = pin_in[7] & is_alt_a[7];
   assign serial1_clock_in = pin_in[7] & is_alt_b[7];
   assign serial0_clock_in = pin_in[6] & is_alt_b[6];
   assign ext_irq_7 = pin_in[5] & is_alt_b[5];
   assign ext_irq_6 = pin_in[4] & is_alt_b[4];
   assign output_enable_in_3 = pin_in[3] & is_alt_a[3];
   assign ext_irq_5 = pin_in[3] & is_alt_b[3];
   assign output_enable_in_2 = pin_in[2] & is_alt_a[2];
   assign ext_irq_4 = pin_in[2] & is_alt_b[2];
   assign output_enable_in_1 = pin_in[1] & is_alt_a[1];
   assign adc_external_trigger = pin_in[1] & is_alt_b[1];
   assign output_enable_in_0 = pin_in[0] & is_alt_a[0];

endmodule

// ---- bench/pdh_properties.sv ----
`timescale 1ns/1ps
module pdh_properties
   import pdh_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire pdh_mode_t mode_in,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] gpio_in,
   input wire logic [7:0] dbus_in,
   input wire logic ext_irq_7,
   input wire logic adc_external_trigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_wresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
   a_wresp: assert property (p_wresp) else $error("write answer late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rresp: assert property (p_rresp) else $error("read answer late");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped");
   property p_rst; $past(srst) && !mode_in.rom_disabled |-> gpio_in == pin_in; endproperty
   a_rst: assert property (p_rst) else $error("pins not gpio after reset");
   property p_excl; (gpio_in & dbus_in) == 8'h00; endproperty
   a_excl: assert property (p_excl) else $error("pin owned twice");
   property p_irq_7; ext_irq_7 |-> pin_in[5]; endproperty
   a_irq_7: assert property (p_irq_7) else $error("irq 7 not from pin");
   property p_adc; adc_external_trigger |-> pin_in[1]; endproperty
   a_adc: assert property (p_adc) else $error("trigger not from pin");
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`include "pdh_consts.svh"
module tb
   import pdh_pkg::*;
;
   logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] s_axi_wdata = 0, r = 3, s_axi_rdata, qb[$], qr[$];
   logic [3:0] s_axi_wstrb = 0;
   pdh_mode_t mode_in = 0;
   logic [7:0] pin_in = 0, gpio_out = 0, gpio_oe = 0, dbus_out = 0, dbus_oe = 0, gpio_in, dbus_in;
   logic pwm_cycle_out = 0, pwm_w_phase_out = 0, pwm_v_phase_out = 0, pwm_u_phase_out = 0;
   logic serial1_clock_out = 0, serial1_clock_oe = 0, serial0_clock_out = 0, serial0_clock_oe = 0;
   logic s_axi_arready, s_axi_rvalid, pwm_counter_clear_in, serial1_clock_in, serial0_clock_in;
   logic output_enable_in_3, output_enable_in_2, output_enable_in_1, output_enable_in_0;
   logic ext_irq_7, ext_irq_6, ext_irq_5, ext_irq_4, adc_external_trigger;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   pdh_pad_t [7:0] pad_drive;
   logic [15:0] v;
   logic [1:0] lanes = 2'b11;
   int fails = 0, checks_done = 0, c, m;
   pdh_pin_function_sel u_pdh_pin_function_sel (.*);
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [1:0] pad_exp(input int cc, input int mm, input int i);
      if ((cc == 0 && mm == 0) || (cc == 1 && mm == 1))
         return {gpio_out[i], !gpio_oe[i]};
      if ((cc == 0 && mm == 1) || (cc == 1 && mm == 0))
         return {dbus_out[i], !dbus_oe[i]};
      if (cc == 3 && i >= 6)
         return i == 7 ? {serial1_clock_out, !serial1_clock_oe} : {serial0_clock_out, !serial0_clock_oe};
      if (cc == 2 && i >= 4)
         return {i == 7 ? pwm_cycle_out : i == 6 ? pwm_w_phase_out : i == 5 ? pwm_v_phase_out :
            pwm_u_phase_out, 1'b0};
      return 2'b01;
   endfunction
   task test_done;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task tmo(input int i);
      if (i == 40)
      begin
         fails++;
         test_done();
      end
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
      logic ta, tw, tr;
      int i;
      @(posedge clk);
      qb.push_back({30'h0, e});
      s_axi_awaddr <= a;
      s_axi_wdata <= {r[31:16], d};
      s_axi_wstrb <= {r[1:0], lanes};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tr = s_axi_bvalid;
         @(posedge clk);
         if (ta)
            s_axi_awvalid <= 0;
         if (tw)
            s_axi_wvalid <= 0;
         if (tr)
            break;
      end
      s_axi_bready <= 0;
      tmo(i);
   endtask
   task rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
      logic ta, tr;
      int i;
      @(posedge clk);
      qr.push_back({16'h0, d});
      qr.push_back({30'h0, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         @(posedge clk);
         if (ta)
            s_axi_arvalid <= 0;
         if (tr)
            break;
      end
      s_axi_rready <= 0;
      tmo(i);
   endtask
   always @(posedge clk)
   begin
      r <= xs(r);
      {pin_in, gpio_out, gpio_oe, dbus_out} <= r;
      {dbus_oe, pwm_cycle_out, pwm_w_phase_out, pwm_v_phase_out, pwm_u_phase_out} <= r[27:16] ^ r[11:0];
      {serial1_clock_out, serial1_clock_oe, serial0_clock_out, serial0_clock_oe} <= r[7:4];
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", qb.pop_front(), s_axi_bresp);
      if (s_axi_rvalid && s_axi_rready)
      begin
         chk("rdata", qr.pop_front(), s_axi_rdata);
         chk("rresp", qr.pop_front(), s_axi_rresp);
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 0;
      rd(`PDH_SEL_OFFSET, `PDH_SEL_RESET, `PDH_RESP_OKAY);
      for (c = 0; c < 4; c++)
      begin
         v = {{7{c[1:0]}}, c == 3 ? 2'b10 : c[1:0]};
         wr(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
         rd(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
         for (m = 0; m < 2; m++)
         begin
            @(posedge clk);
            mode_in <= m == 0 ? 3'b000 : c == 0 ? 3'b110 : 3'b001;
            @(negedge clk);
            chk("gpio_in", (c == 0 && m == 0) || (c == 1 && m == 1) ? pin_in : 8'h00, gpio_in);
            chk("dbus_in", (c == 0 && m == 1) || (c == 1 && m == 0) ? pin_in : 8'h00, dbus_in);
            chk("alt_a_in", {pin_in[7], pin_in[3:0]} & (c == 2 ? 5'h1f : c == 3 ? 5'h01 : 5'h00),
               {pwm_counter_clear_in, output_enable_in_3, output_enable_in_2, output_enable_in_1,
               output_enable_in_0});
            chk("alt_b_in", c == 3 ? pin_in[7:1] : 7'h00, {serial1_clock_in, serial0_clock_in,
               ext_irq_7, ext_irq_6, ext_irq_5, ext_irq_4, adc_external_trigger});
            if (c == 2)
               chk("pwm_pads", {pwm_cycle_out, 1'b0, pwm_w_phase_out, 1'b0, pwm_v_phase_out, 1'b0,
                  pwm_u_phase_out, 1'b0}, pad_drive[7:4]);
            for (int i = 0; i < 8; i++)
               chk("pad_drive", pad_exp(c, m, i), pad_drive[i]);
         end
      end
      $display("code test done");
      wr(12'h004, 16'h5555, `PDH_RESP_SLVERR);
      rd(12'h004, 16'h0000, `PDH_RESP_SLVERR);
      rd(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
      repeat (8)
      begin
         v = {r[15:2], r[1] & ~r[0], r[0]};
         wr(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
         rd(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
      end
      lanes = 2'b01;
      v = {v[15:8], 8'h34};
      wr(`PDH_SEL_OFFSET, 16'hc934, `PDH_RESP_OKAY);
      rd(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
      lanes = 2'b10;
      v = {8'h21, v[7:0]};
      wr(`PDH_SEL_OFFSET, 16'h21c4, `PDH_RESP_OKAY);
      rd(`PDH_SEL_OFFSET, v, `PDH_RESP_OKAY);
      lanes = 2'b11;
      $display("bus test done");
      @(posedge clk);
      srst <= 1;
      repeat (3) @(posedge clk);
      srst <= 0;
      rd(`PDH_SEL_OFFSET, `PDH_SEL_RESET, `PDH_RESP_OKAY);
      $display("reset test done");
      test_done();
   end
endmodule
bind pdh_pin_function_sel pdh_properties u_pdh_properties (.*);
